// [hw/ccarr_defs.vh]
// Constants for the sixteen-channel capture/compare array.
// Included by the array module only; defines nothing but macros.
`ifndef CCARR_DEFS_VH
`define CCARR_DEFS_VH

// Register indices (word addresses)
`define CCARR_A_TCTL 6'h00
`define CCARR_A_T0 6'h01
`define CCARR_A_T1 6'h02
`define CCARR_A_REL0 6'h03
`define CCARR_A_REL1 6'h04
`define CCARR_A_STAT 6'h05
`define CCARR_A_MASK 6'h06
`define CCARR_A_DREG 6'h07
`define CCARR_A_MODE 6'h10
`define CCARR_A_CCV 6'h20

// Timer control field positions, one byte per timer
`define CCARR_TC_RUN 0
`define CCARR_TC_SRCL 1
`define CCARR_TC_SRCH 3
`define CCARR_TC_STAG 4
`define CCARR_TC_W 8

// Count sources
`define CCARR_SRC_PRE 3'h0
`define CCARR_SRC_AUX 3'h1
`define CCARR_SRC_EXTR 3'h2
`define CCARR_SRC_EXTF 3'h3

// Channel mode word fields
`define CCARR_M_MODEL 0
`define CCARR_M_MODEH 2
`define CCARR_M_TSEL 3
`define CCARR_M_SEV 4

// Channel modes
`define CCARR_MD_OFF 3'h0
`define CCARR_MD_CAPR 3'h1
`define CCARR_MD_CAPF 3'h2
`define CCARR_MD_CAPB 3'h3
`define CCARR_MD_CMP0 3'h4
`define CCARR_MD_CMP1 3'h5
`define CCARR_MD_CMP2 3'h6
`define CCARR_MD_CMP3 3'h7

`define CCARR_STAG_DIV 3'h7
`define CCARR_PRE_MAX 3'h7

`endif

// [hw/ccarr_capture_compare.v]
// Sixteen-channel capture/compare array with two reloadable time bases.
// Assumes pins are asynchronous to clock; register port is synchronous.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ccarr_defs.vh"

module ccarr_capture_compare (
   input wire clock,
   input wire rst_n,
   input wire [5:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [15:0] regRdData,
   input wire [15:0] pinIn,
   output wire [15:0] pinOut,
   output wire [15:0] pinOe,
   input wire auxOverflow,
   input wire [1:0] extCount,
   output wire irq
);

   // Mode of a channel is decoded in several places
   function isCompare;
      input [2:0] md;
      begin
         isCompare = md[2];
      end
   endfunction

   function drivesPin;
      input [2:0] md;
      begin
         drivesPin = (md == `CCARR_MD_CMP1) || (md == `CCARR_MD_CMP3);
      end
   endfunction

   reg [15:0] tctl_r;
   reg [15:0] timer_r [0:1];
   reg [15:0] reload_r [0:1];
   reg [15:0] ccv_r [0:15];
   reg [4:0] mode_r [0:15];
   reg [15:0] stat_r;
   reg [15:0] mask_r;
   reg [7:0] dreg_r;
   reg [15:0] pinLvl_r;
   reg [15:0] done_r;
   reg [15:0] pinS1_r;
   reg [15:0] pinS2_r;
   reg [15:0] pinS3_r;
   reg [15:0] pinStab_r;
   reg [1:0] extS1_r;
   reg [1:0] extS2_r;
   reg [1:0] extS3_r;
   reg [1:0] extStab_r;
   reg [2:0] auxS_r;
   reg auxStab_r;
   reg [2:0] pre_r [0:1];
   reg [2:0] stag_r;
   reg [15:0] extEdge;
   wire [1:0] tick;
   wire [1:0] ovf;
   wire [15:0] capEv;
   wire [15:0] cmpEv;
   wire [15:0] tglEv;
   wire [15:0] setEv;
   wire [15:0] clrEv;
   wire [15:0] drvMask;
   wire auxEdge;
   genvar g;

   // Three-stage synchronisers; the first stage feeds only the second
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pinS1_r <= 16'h0000;
         pinS2_r <= 16'h0000;
         pinS3_r <= 16'h0000;
         pinStab_r <= 16'h0000;
         extS1_r <= 2'h0;
         extS2_r <= 2'h0;
         extS3_r <= 2'h0;
         extStab_r <= 2'h0;
         auxS_r <= 3'h0;
         auxStab_r <= 1'b0;
      end else begin
         pinS1_r <= pinIn;
         pinS2_r <= pinS1_r;
         pinS3_r <= pinS2_r;
         // Accept a level only once stages two and three agree
         pinStab_r <= (pinS2_r & pinS3_r) | (pinStab_r & (pinS2_r | pinS3_r));
         extS1_r <= extCount;
         extS2_r <= extS1_r;
         extS3_r <= extS2_r;
         extStab_r <= (extS2_r & extS3_r) | (extStab_r & (extS2_r | extS3_r));
         auxS_r <= {auxS_r[1:0], auxOverflow};
         auxStab_r <= (auxS_r[1] & auxS_r[2]) | (auxStab_r & (auxS_r[1] | auxS_r[2]));
      end
   end

   assign auxEdge = (auxS_r[1] & auxS_r[2]) & ~auxStab_r;

   // Staggered mode gives a timer one slot in eight, the same slot for both timers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stag_r <= 3'h0;
      end else begin
         stag_r <= stag_r + 3'h1;
      end
   end

   // Per-timer tick, overflow, reload
   generate
      for (g = 0; g < 2; g = g + 1) begin : gTimer
         wire [2:0] src = tctl_r[g*`CCARR_TC_W+`CCARR_TC_SRCH:g*`CCARR_TC_W+`CCARR_TC_SRCL];
         wire run = tctl_r[g*`CCARR_TC_W+`CCARR_TC_RUN];
         wire stag = tctl_r[g*`CCARR_TC_W+`CCARR_TC_STAG];
         wire extRise = extS2_r[g] & extS3_r[g] & ~extStab_r[g];
         wire extFall = ~extS2_r[g] & ~extS3_r[g] & extStab_r[g];
         reg t;
         always @* begin
            case (src)
               `CCARR_SRC_PRE: t = (pre_r[g] == `CCARR_PRE_MAX);
               `CCARR_SRC_AUX: t = auxEdge;
               `CCARR_SRC_EXTR: t = extRise;
               `CCARR_SRC_EXTF: t = extFall;
               default: t = 1'b1;
            endcase
         end
         // Staggered mode: one update per eight cycles
         assign tick[g] = run & t & (~stag | (stag_r == `CCARR_STAG_DIV));
         assign ovf[g] = tick[g] & (timer_r[g] == 16'hffff);
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               pre_r[g] <= 3'h0;
               timer_r[g] <= 16'h0000;
            end else begin
               pre_r[g] <= run ? pre_r[g] + 3'h1 : 3'h0;
               if (regWrite && regAddr == `CCARR_A_T0 + g) begin
                  timer_r[g] <= regWrData;
               end else if (ovf[g]) begin
                  timer_r[g] <= reload_r[g];
               end else if (tick[g]) begin
                  timer_r[g] <= timer_r[g] + 16'h0001;
               end
            end
         end
      end
   endgenerate

   // Per-channel capture and compare decisions
   generate
      for (g = 0; g < 16; g = g + 1) begin : gChan
         wire [2:0] md = mode_r[g][`CCARR_M_MODEH:`CCARR_M_MODEL];
         wire ts = mode_r[g][`CCARR_M_TSEL];
         wire sev = mode_r[g][`CCARR_M_SEV];
         wire rise = pinS2_r[g] & pinS3_r[g] & ~pinStab_r[g];
         wire fall = ~pinS2_r[g] & ~pinS3_r[g] & pinStab_r[g];
         wire inDbl = (g < 8) ? dreg_r[g % 8] : dreg_r[g % 8];
         wire match = isCompare(md) & tick[ts] & (timer_r[ts] == ccv_r[g]);
         always @* begin
            case (md)
               `CCARR_MD_CAPR: extEdge[g] = rise;
               `CCARR_MD_CAPF: extEdge[g] = fall;
               `CCARR_MD_CAPB: extEdge[g] = rise | fall;
               default: extEdge[g] = 1'b0;
            endcase
         end
         assign capEv[g] = extEdge[g];
         // Mode 2 and 3 limited once per period
         assign cmpEv[g] = match & ~done_r[g];
         assign tglEv[g] = cmpEv[g] & (md == `CCARR_MD_CMP1) & ~inDbl;
         // Set on match, clear on overflow
         assign setEv[g] = cmpEv[g] & (md == `CCARR_MD_CMP3) & ~inDbl;
         assign clrEv[g] = ovf[ts] & (md == `CCARR_MD_CMP3) & ~inDbl;
         assign drvMask[g] = drivesPin(md) & ~(inDbl & (g >= 8));
         assign pinOut[g] = pinLvl_r[g];
         assign pinOe[g] = drvMask[g];
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               done_r[g] <= 1'b0;
               pinLvl_r[g] <= 1'b0;
               ccv_r[g] <= 16'h0000;
            end else begin
               if (regWrite && regAddr == `CCARR_A_MODE + g) begin
                  done_r[g] <= 1'b0;
               end else if (cmpEv[g] && (sev || md == `CCARR_MD_CMP2 || md == `CCARR_MD_CMP3)) begin
                  done_r[g] <= 1'b1;
               end else if (ovf[ts] && !sev) begin
                  done_r[g] <= 1'b0;
               end
               if (g < 8 && inDbl && (cmpEv[g] || cmpEv[(g + 8) % 16])) begin
                  pinLvl_r[g] <= ~pinLvl_r[g];
               end else if (tglEv[g]) begin
                  pinLvl_r[g] <= ~pinLvl_r[g];
               end else if (setEv[g]) begin
                  pinLvl_r[g] <= 1'b1;
               end else if (clrEv[g]) begin
                  pinLvl_r[g] <= 1'b0;
               end
               if (capEv[g]) begin
                  ccv_r[g] <= timer_r[ts];
               end else if (regWrite && regAddr == `CCARR_A_CCV + g) begin
                  ccv_r[g] <= regWrData;
               end
            end
         end
      end
   endgenerate

   // Mode 0/2 interrupt-only; all compare events flag
   // Capture sets channel request
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= 16'h0000;
      end else begin
         // Set wins over the write-one clear
         stat_r <= (stat_r & ~(regWrite && regAddr == `CCARR_A_STAT ? regWrData : 16'h0000)) | capEv | cmpEv;
      end
   end

   assign irq = |(stat_r & mask_r);

   // Control registers
   always @(posedge clock or negedge rst_n) begin : pCtl
      integer i;
      if (!rst_n) begin
         tctl_r <= 16'h0000;
         reload_r[0] <= 16'h0000;
         reload_r[1] <= 16'h0000;
         mask_r <= 16'h0000;
         dreg_r <= 8'h00;
         for (i = 0; i < 16; i = i + 1) begin
            mode_r[i] <= 5'h00;
         end
      end else if (regWrite) begin
         if (regAddr == `CCARR_A_TCTL) begin
            tctl_r <= regWrData;
         end
         if (regAddr == `CCARR_A_REL0) begin
            reload_r[0] <= regWrData;
         end
         if (regAddr == `CCARR_A_REL1) begin
            reload_r[1] <= regWrData;
         end
         if (regAddr == `CCARR_A_MASK) begin
            mask_r <= regWrData;
         end
         if (regAddr == `CCARR_A_DREG) begin
            dreg_r <= regWrData[7:0];
         end
         if (regAddr[5:4] == 2'h1) begin
            mode_r[regAddr[3:0]] <= regWrData[4:0];
         end
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 16'h0000;
      end else if (regRead) begin
         if (regAddr[5:4] == 2'h2) begin
            regRdData <= ccv_r[regAddr[3:0]];
         end else if (regAddr[5:4] == 2'h1) begin
            regRdData <= {11'h000, mode_r[regAddr[3:0]]};
         end else begin
            case (regAddr)
               `CCARR_A_TCTL: regRdData <= tctl_r;
               `CCARR_A_T0: regRdData <= timer_r[0];
               `CCARR_A_T1: regRdData <= timer_r[1];
               `CCARR_A_REL0: regRdData <= reload_r[0];
               `CCARR_A_REL1: regRdData <= reload_r[1];
               `CCARR_A_STAT: regRdData <= stat_r;
               `CCARR_A_MASK: regRdData <= mask_r;
               `CCARR_A_DREG: regRdData <= {8'h00, dreg_r};
               default: regRdData <= 16'h0000;
            endcase
         end
      end else begin
         regRdData <= 16'h0000;
      end
   end

endmodule // ccarr_capture_compare

// [tb/ccarr_checker_asserts.sv]
// Checker: register readback, pin drive and irq relations.
// Bound to the array top; sees only its ports.
`timescale 1ns/1ps
module ccarr_checker (
   input wire clock,
   input wire rst_n,
   input wire [5:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   input wire [15:0] regRdData,
   input wire [15:0] pinOut,
   input wire [15:0] pinOe,
   input wire irq
);
   reg [15:0] mask_r, oe_r, quiet_r;
   reg [7:0] dreg_r;
   wire [2:0] md = regWrData[2:0];
   wire hole = regAddr[5:3] == 3'h1 || regAddr[5:4] == 2'h3;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Shadows of written registers, the real ones are hidden
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= 16'h0000;
         dreg_r <= 8'h00;
         oe_r <= 16'h0000;
         quiet_r <= 16'h0000;
      end else if (regWrite) begin
         if (regAddr == 6'h06)
            mask_r <= regWrData;
         if (regAddr == 6'h07)
            dreg_r <= regWrData[7:0];
         if (regAddr[5:4] == 2'h1) begin
            oe_r[regAddr[3:0]] <= md == 3'h5 || md == 3'h7;
            quiet_r[regAddr[3:0]] <= md == 3'h4 || md == 3'h6;
         end
      end
   end
   // Interrupt-only channels never move their pin, except paired channels 0-7
   property quietP;
      ((pinOut ^ $past(pinOut)) & quiet_r & $past(quiet_r) & ~{8'h00, dreg_r} & ~{8'h00, $past(dreg_r)}) == 16'h0000;
   endproperty
   rd_idle_a: assert property (!regRead |=> regRdData == 16'h0000)
      else $error("read data outside a read");
   hole_zero_a: assert property (regRead && hole |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   mask_read_a: assert property (regRead && regAddr == 6'h06 |=> regRdData == mask_r)
      else $error("mask readback wrong");
   pair_read_a: assert property (regRead && regAddr == 6'h07 |=> regRdData[7:0] == dreg_r)
      else $error("pair readback wrong");
   drive_mode_a: assert property (pinOe == (oe_r & ~{dreg_r, 8'h00}))
      else $error("pin enable wrong");
   irq_masked_a: assert property (mask_r == 16'h0000 |-> !irq)
      else $error("irq with all masked");
   pin_quiet_a: assert property (quietP)
      else $error("quiet pin moved");
   reset_idle_a: assert property ($rose(rst_n) |-> pinOut == 16'h0000 && pinOe == 16'h0000 && !irq)
      else $error("outputs not idle after reset");
   // Scenario reach
   cover property ($rose(irq));
   cover property ($rose(pinOut[2]) ##[1:300] $fell(pinOut[2]));
   cover property (regRead && regAddr == 6'h21 ##1 regRdData == 16'h1234);
endmodule // ccarr_checker

bind ccarr_capture_compare ccarr_checker u_chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .pinOut(pinOut), .pinOe(pinOe), .irq(irq));

// [tb/ccarr_pin_model.sv]
// Far side of the channel pins: board level per pin.
// Assumes the bench sets extLevel; LAG models slow pins.
`timescale 1ns/1ps
module ccarr_pin_model #(
   parameter integer LAG = 0
) (
   input wire [15:0] pinOut,
   input wire [15:0] pinOe,
   input wire [15:0] extLevel,
   output wire [15:0] pinIn
);
   // sixteen independent pins
   // Driven pins read back the unit's level, others the board's
   assign #(LAG) pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // ccarr_pin_model

// [tb/test_capture_compare_array.sv]
// Bench for the capture/compare array through its register port.
// Assumes the pin model closes the pins; one clock domain.
`timescale 1ns/1ps
module test_capture_compare_array;
   reg clock = 1'b0;
   reg rst_n = 1'b0;
   reg regWrite = 1'b0;
   reg regRead = 1'b0;
   reg [5:0] regAddr = 6'h00;
   reg [15:0] regWrData = 16'h0000;
   reg [15:0] extLevel = 16'h0000;
   reg auxOverflow = 1'b0;
   reg [1:0] extCount = 2'h0;
   wire [15:0] regRdData, pinOut, pinOe, pinIn;
   wire irq;
   integer mismatches = 0;
   integer samplesChecked = 0;
   integer i;
   // Count inputs driven by the bench for the source scenario
   ccarr_capture_compare u_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe), .auxOverflow(auxOverflow), .extCount(extCount), .irq(irq));
   ccarr_pin_model u_pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));
   // Clock, 4 ns period
   initial
      forever #2 clock = ~clock;
   task end_sim;
      begin
         if (mismatches == 0 && samplesChecked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task check(input [15:0] seen, input [15:0] exp);
      begin
         samplesChecked = samplesChecked + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clock);
   endtask
   // Write or read: one-cycle strobe, then a gap so no strobe is set twice
   task access(input w, input [5:0] a, input [15:0] d);
      begin
         regAddr <= a;
         regWrData <= d;
         regWrite <= w;
         regRead <= !w;
         @(posedge clock);
         regWrite <= 1'b0;
         regRead <= 1'b0;
         #1;
         if (!w)
            check(regRdData, d);
         @(posedge clock);
      end
   endtask
   // Main sequence
   initial begin
      idle(3);
      rst_n <= 1'b1;
      idle(1);
      access(0, 6'h05, 16'h0000);
      access(0, 6'h0a, 16'h0000);
      check(pinOe, 16'h0000);
      // Stopped timer, so the captured value is known
      access(1, 6'h01, 16'h1234);
      access(1, 6'h06, 16'h0002);
      for (i = 1; i < 4; i = i + 1) begin
         access(1, 6'h21, 16'h0000);
         access(1, 6'h11, i[15:0]);
         extLevel[1] <= 1'b1;
         idle(8);
         check(irq, i != 2);
         access(1, 6'h05, 16'h0002);
         extLevel[1] <= 1'b0;
         idle(8);
         access(0, 6'h05, {14'h0000, i != 1, 1'b0});
         access(1, 6'h05, 16'h0002);
         access(0, 6'h21, 16'h1234);
      end
      // Masked event keeps irq low until unmasked
      access(1, 6'h06, 16'h0000);
      extLevel[1] <= 1'b1;
      idle(8);
      check(irq, 1'b0);
      access(1, 6'h06, 16'h0002);
      check(irq, 1'b1);
      access(1, 6'h05, 16'h0002);
      check(irq, 1'b0);
      // Timer 0 every cycle from ff00: 256-cycle period
      access(1, 6'h03, 16'hff00);
      access(1, 6'h01, 16'hff00);
      access(1, 6'h20, 16'hff80);
      access(1, 6'h10, 16'h0005);
      access(1, 6'h22, 16'hfff0);
      access(1, 6'h12, 16'h0007);
      access(1, 6'h23, 16'hff40);
      access(1, 6'h13, 16'h0004);
      access(1, 6'h24, 16'hff80);
      access(1, 6'h14, 16'h0015);
      access(1, 6'h25, 16'hff20);
      access(1, 6'h15, 16'h0005);
      access(1, 6'h2d, 16'hffa0);
      access(1, 6'h1d, 16'h0005);
      access(1, 6'h07, 16'h0020);
      access(1, 6'h06, 16'h0008);
      check(pinOe, 16'h0035);
      access(1, 6'h00, 16'h0009);
      idle(98);
      check(pinOut & 16'h0035, 16'h0020);
      check(irq, 1'b1);
      access(1, 6'h05, 16'h0008);
      check(irq, 1'b0);
      idle(99);
      check(pinOut & 16'h0035, 16'h0011);
      idle(50);
      check(pinOut & 16'h0035, 16'h0015);
      idle(50);
      check(pinOut & 16'h0035, 16'h0031);
      check(irq, 1'b0);
      idle(50);
      check(irq, 1'b1);
      idle(100);
      check(pinOut & 16'h0035, 16'h0010);
      // Timer 1 counts external rising edges, then auxiliary edges
      access(1, 6'h02, 16'h0000);
      access(1, 6'h00, 16'h0509);
      for (i = 0; i < 3; i = i + 1) begin
         extCount[1] <= 1'b1;
         idle(8);
         extCount[1] <= 1'b0;
         idle(8);
      end
      access(0, 6'h02, 16'h0003);
      access(1, 6'h00, 16'h0309);
      for (i = 0; i < 2; i = i + 1) begin
         auxOverflow <= 1'b1;
         idle(8);
         auxOverflow <= 1'b0;
         idle(8);
      end
      access(0, 6'h02, 16'h0005);
      end_sim;
   end
   // Watchdog: the run needs about 680 cycles
   initial begin
      #20000;
      mismatches = mismatches + 1;
      end_sim;
   end
endmodule // test_capture_compare_array
